/* File: asp_top.sv */
/*
 * Asynchronous serial port with its baud timers, register port,
 * transmit and receive engines.
 * Assumes a 100 MHz ref_clk, synchronous active-high rst and a register
 * master that never issues read and write strobes together.
 */
`timescale 1ns/1ps
`default_nettype none
module asp_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic irq_enable,
    input wire logic serial_in_pin,
    input wire logic baud_timer_ext_input,
    input wire logic xosc_in,
    output logic serial_out_pin,
    output logic irq_req
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] rx_s_r; // Receive pin pair
    logic [1:0] ext_s_r; // External timer input pair
    logic [1:0] xo_s_r; // Oscillator pair
    logic rx_prev_r; // Previous synchronised receive level

    // Two flops for each asynchronous pin; idle line is high
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_s_r <= 2'h3;
            ext_s_r <= 2'h0;
            xo_s_r <= 2'h0;
            rx_prev_r <= 1'b1;
        end else begin
            rx_s_r <= {rx_s_r[0], serial_in_pin};
            ext_s_r <= {ext_s_r[0], baud_timer_ext_input};
            xo_s_r <= {xo_s_r[0], xosc_in};
            rx_prev_r <= rx_s_r[1];
        end
    end

    // ------------------------------------------------------------------
    // Software-visible state and the hidden receive timer
    // ------------------------------------------------------------------
    logic width_sel_r; // Frame width select
    logic mce_r; // Multiprocessor check enable
    logic ren_r; // Receive enable
    logic rb_r; // Received stop bit
    logic ti_r; // Transmit done flag
    logic ri_r; // Receive done flag
    logic [7:0] rbuf_r; // Receive buffer
    logic [7:0] reload_r; // Baud timer reload
    logic [7:0] tlow_r; // Baud timer low count (transmit side)
    logic [7:0] rxt_r; // Hidden receive timer
    logic run_r; // Timer run
    logic [2:0] src_r; // Clock source select
    logic [7:0] ctrl_rd;
    logic wr_ctrl;
    logic wr_buf;
    logic tick;

    assign wr_ctrl = reg_wr && (reg_addr == asp_pkg::ASP_ADDR_CTRL);
    assign wr_buf = reg_wr && (reg_addr == asp_pkg::ASP_ADDR_BUF);

    // Tick source
    asp_tick_gen u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .src_sel(src_r),
        .xosc_sync(xo_s_r[1]),
        .ext_sync(ext_s_r[1]),
        .tick(tick)
    );

    // ------------------------------------------------------------------
    // Baud timers
    // ------------------------------------------------------------------
    logic tx_ovf;
    logic rx_ovf;
    logic tx_half_r; // Transmit overflow halving bit
    logic rx_half_r; // Receive overflow halving bit
    logic start_edge;
    logic rx_busy_r;

    // Function used for both timers: overflow at 0xff with tick
    function automatic logic asp_ovf(input logic [7:0] cnt, input logic tk, input logic rn);
        asp_ovf = rn && tk && (cnt == 8'hff);
    endfunction

    assign tx_ovf = asp_ovf(tlow_r, tick, run_r); // [RULE1] [RULE5]
    assign rx_ovf = asp_ovf(rxt_r, tick, run_r); // [RULE2] [RULE5]
    assign start_edge = rx_prev_r && !rx_s_r[1] && !rx_busy_r && ren_r; // [RULE18]

    // Transmit timer: counts up, reloads on overflow, software may write it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tlow_r <= asp_pkg::ASP_RST_BYTE;
        end else if (reg_wr && (reg_addr == asp_pkg::ASP_ADDR_TLOW)) begin
            tlow_r <= reg_wdata;
        end else if (tx_ovf) begin
            tlow_r <= reload_r; // [RULE1]
        end else if (run_r && tick) begin
            tlow_r <= tlow_r + 8'h01;
        end
    end

    // Receive timer: same reload, forced reload on start edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rxt_r <= asp_pkg::ASP_RST_BYTE;
        end else if (start_edge || rx_ovf) begin
            rxt_r <= reload_r; // [RULE2] [RULE4]
        end else if (run_r && tick) begin
            rxt_r <= rxt_r + 8'h01;
        end
    end

    // Halve each overflow stream into bit-rate pulses
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_half_r <= 1'b0;
            rx_half_r <= 1'b0;
        end else begin
            if (tx_ovf) begin
                tx_half_r <= !tx_half_r; // [RULE3]
            end
            if (start_edge) begin
                rx_half_r <= 1'b0; // [RULE4]
            end else if (rx_ovf) begin
                rx_half_r <= !rx_half_r; // [RULE3]
            end
        end
    end

    logic tx_bit_tick;
    assign tx_bit_tick = tx_ovf && tx_half_r;

    // ------------------------------------------------------------------
    // Transmit path with two-entry buffer
    // ------------------------------------------------------------------
    logic [7:0] txq_data;
    logic txq_valid;
    logic txq_take;
    logic wbuf_ready; // Low when both entries hold bytes; writes then dropped
    logic [9:0] tx_sh_r; // Frame shifter: stop, data; start bit driven directly
    logic [3:0] tx_cnt_r; // Bits left in frame
    logic tx_out_r;

    asp_skid_buf #(.WIDTH(8)) u_txq (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_data(reg_wdata),
        .in_valid(wr_buf), // [RULE9]
        .in_ready(wbuf_ready),
        .out_data(txq_data),
        .out_valid(txq_valid),
        .out_ready(txq_take)
    );
    assign txq_take = (tx_cnt_r == 4'h0) && tx_bit_tick;

    // Shifter loads at a bit boundary so every bit lasts a full period
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_sh_r <= 10'h3ff;
            tx_cnt_r <= 4'h0;
            tx_out_r <= 1'b1; // [RULE18]
        end else if (tx_bit_tick) begin
            if (tx_cnt_r != 4'h0) begin
                tx_out_r <= tx_sh_r[0]; // [RULE8] LSB first
                tx_sh_r <= {1'b1, tx_sh_r[9:1]};
                tx_cnt_r <= tx_cnt_r - 4'h1;
            end else if (txq_valid) begin
                tx_out_r <= 1'b0; // Start bit [RULE8]
                tx_sh_r <= {1'b1, 1'b1, txq_data};
                tx_cnt_r <= asp_pkg::ASP_DATA_BITS + 4'h1;
            end else begin
                tx_out_r <= 1'b1;
            end
        end
    end
    assign serial_out_pin = tx_out_r;

    // ------------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------------
    logic [3:0] rx_bit_r; // Bits received so far
    logic [7:0] rx_sh_r; // Incoming data shifter
    logic rx_sample;
    logic rx_load_ok;

    // First overflow after the forced reload is half a bit: mid start bit
    assign rx_sample = rx_busy_r && rx_ovf && !rx_half_r; // [RULE19] [RULE3]
    // Load needs done flag clear and, when checked, a high stop bit
    assign rx_load_ok = !ri_r && (!mce_r || rx_s_r[1]); // [RULE12] [RULE15]

    // Bit sampling engine, runs alongside the transmitter [RULE17]
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_busy_r <= 1'b0;
            rx_bit_r <= 4'h0;
            rx_sh_r <= asp_pkg::ASP_RST_BYTE;
        end else if (start_edge) begin
            rx_busy_r <= 1'b1; // [RULE11]
            rx_bit_r <= 4'h0;
        end else if (rx_sample) begin
            if (rx_bit_r == 4'h0 && rx_s_r[1]) begin
                rx_busy_r <= 1'b0; // False start, back to idle
            end else if (rx_bit_r == asp_pkg::ASP_DATA_BITS + 4'h1) begin
                rx_busy_r <= 1'b0; // Stop bit taken
            end else begin
                if (rx_bit_r != 4'h0) begin
                    rx_sh_r <= {rx_s_r[1], rx_sh_r[7:1]}; // [RULE8]
                end
                rx_bit_r <= rx_bit_r + 4'h1;
            end
        end
    end

    logic rx_stop_evt;
    assign rx_stop_evt = rx_sample && (rx_bit_r == asp_pkg::ASP_DATA_BITS + 4'h1);

    // ------------------------------------------------------------------
    // Control register and flags; hardware set wins over software clear
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            width_sel_r <= 1'b0;
            mce_r <= 1'b0;
            ren_r <= 1'b0;
        end else if (wr_ctrl) begin
            width_sel_r <= reg_wdata[asp_pkg::ASP_BIT_WIDTH]; // [RULE7]
            mce_r <= reg_wdata[asp_pkg::ASP_BIT_MCE];
            ren_r <= reg_wdata[asp_pkg::ASP_BIT_REN]; // [RULE11]
        end
    end

    // Transmit done: set as the stop bit goes out
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ti_r <= 1'b0;
        end else if (tx_bit_tick && tx_cnt_r == 4'h1) begin
            ti_r <= 1'b1; // [RULE10]
        end else if (wr_ctrl) begin
            ti_r <= reg_wdata[asp_pkg::ASP_BIT_TI];
        end
    end

    // Receive done, stop bit and buffer load; nothing moves on failure
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ri_r <= 1'b0;
            rb_r <= 1'b0;
            rbuf_r <= asp_pkg::ASP_RST_BYTE;
        end else if (rx_stop_evt && rx_load_ok) begin
            ri_r <= 1'b1; // [RULE13]
            rb_r <= rx_s_r[1]; // [RULE13]
            rbuf_r <= rx_sh_r; // [RULE13]
        end else if (wr_ctrl) begin
            ri_r <= reg_wdata[asp_pkg::ASP_BIT_RI]; // [RULE14]
            rb_r <= reg_wdata[asp_pkg::ASP_BIT_RB];
        end
    end

    // Timer configuration
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reload_r <= asp_pkg::ASP_RST_BYTE;
            run_r <= 1'b0;
            src_r <= asp_pkg::ASP_SRC_SYS;
        end else if (reg_wr && reg_addr == asp_pkg::ASP_ADDR_RELOAD) begin
            reload_r <= reg_wdata;
        end else if (reg_wr && reg_addr == asp_pkg::ASP_ADDR_TCFG) begin
            run_r <= reg_wdata[asp_pkg::ASP_BIT_RUN];
            src_r <= reg_wdata[2:0];
        end
    end

    // Interrupt request from either flag
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= irq_enable && (ti_r || ri_r); // [RULE16]
        end
    end

    // ------------------------------------------------------------------
    // Read port: data one cycle after the strobe, zero otherwise
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[asp_pkg::ASP_BIT_WIDTH] = width_sel_r;
        ctrl_rd[asp_pkg::ASP_BIT_MCE] = mce_r;
        ctrl_rd[asp_pkg::ASP_BIT_REN] = ren_r;
        ctrl_rd[asp_pkg::ASP_BIT_RB] = rb_r;
        ctrl_rd[asp_pkg::ASP_BIT_TI] = ti_r;
        ctrl_rd[asp_pkg::ASP_BIT_RI] = ri_r;
    end

    always_ff @(posedge ref_clk) begin
        if (rst || !reg_rd) begin
            reg_rdata <= 8'h00;
        end else begin
            unique case (reg_addr)
                asp_pkg::ASP_ADDR_CTRL: reg_rdata <= ctrl_rd;
                asp_pkg::ASP_ADDR_BUF: reg_rdata <= rbuf_r;
                asp_pkg::ASP_ADDR_RELOAD: reg_rdata <= reload_r;
                asp_pkg::ASP_ADDR_TCFG: reg_rdata <= {4'h0, run_r, src_r};
                asp_pkg::ASP_ADDR_TLOW: reg_rdata <= tlow_r;
                default: reg_rdata <= 8'h00; // Unmapped reads zero
            endcase
        end
    end
endmodule // asp_top
`default_nettype wire

/* File: asp_pkg.sv */
/*
 * Constants shared by the asynchronous serial port: register offsets,
 * control bit positions, reset values and baud clock source codes.
 * Assumes a single 100 MHz system clock and a plain register port.
 */
// Summary of operation
// RULE1: Transmit rate from 8-bit auto-reload timer overflow
// RULE2: Hidden receive timer shares reload, runs when enabled
// RULE3: Both overflows halved to give bit rates
// RULE4: Start edge forces receive timer reload
// RULE5: Overflow every 256 minus reload ticks
// RULE6: Timer ticks from one of six sources
// RULE7: Control bit 7 selects 8 or 9 bit; the bit is only stored, frames stay 8-bit
// RULE8: Ten bits: start, eight LSB first, stop
// RULE9: Buffer write starts a transmission
// RULE10: Transmit done set at stop bit start
// RULE11: Receive only while receive enable set
// RULE12: Load only if done clear, stop checked
// RULE13: Load stores byte, stop bit, sets done
// RULE14: Failed load changes nothing
// RULE15: Overrun keeps first byte, drops next
// RULE16: Interrupt request when either flag set
// RULE17: Transmit and receive run independently
// RULE18: Idle line high, start is falling edge
// RULE19: Sample each bit near its middle
package asp_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [2:0] ASP_ADDR_CTRL = 3'h0; // Serial control register
    localparam logic [2:0] ASP_ADDR_BUF = 3'h1; // Serial buffer
    localparam logic [2:0] ASP_ADDR_RELOAD = 3'h2; // Baud timer reload byte
    localparam logic [2:0] ASP_ADDR_TCFG = 3'h3; // Baud timer run and source
    localparam logic [2:0] ASP_ADDR_TLOW = 3'h4; // Baud timer low count
    // ------------------------------------------------------------------
    // Control register bit positions, plus the timer config run bit
    // ------------------------------------------------------------------
    localparam int ASP_BIT_WIDTH = 7; // Frame width select
    localparam int ASP_BIT_MCE = 5; // Multiprocessor check enable
    localparam int ASP_BIT_REN = 4; // Receive enable
    localparam int ASP_BIT_RB = 2; // Received stop bit
    localparam int ASP_BIT_TI = 1; // Transmit done flag
    localparam int ASP_BIT_RI = 0; // Receive done flag
    localparam int ASP_BIT_RUN = 3; // Timer run bit in timer config
    // ------------------------------------------------------------------
    // Reset values and frame constants
    // ------------------------------------------------------------------
    localparam logic [7:0] ASP_RST_BYTE = 8'h00;
    localparam logic [3:0] ASP_DATA_BITS = 4'h8; // Data bits per frame
    // ------------------------------------------------------------------
    // Baud clock sources
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ASP_SRC_SYS, ASP_SRC_DIV4, ASP_SRC_DIV12, ASP_SRC_DIV48,
        ASP_SRC_XOSC8, ASP_SRC_EXT
    } asp_src_e;
    localparam logic [5:0] ASP_DIV4_LAST = 6'h03;
    localparam logic [5:0] ASP_DIV12_LAST = 6'h0b;
    localparam logic [5:0] ASP_DIV48_LAST = 6'h2f;
    localparam logic [3:0] ASP_XOSC_LAST = 4'hf; // 16 edges, eight periods
endpackage

/* File: asp_tick_gen.sv */
/*
 * Baud tick source for the serial port timers.
 * Assumes pin-level inputs have already been synchronised to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module asp_tick_gen (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [2:0] src_sel,
    input wire logic xosc_sync,
    input wire logic ext_sync,
    output logic tick
);
    // ------------------------------------------------------------------
    // Prescaler state
    // ------------------------------------------------------------------
    logic [5:0] pre_r; // Free prescaler count
    logic [3:0] xcnt_r; // External oscillator edge count
    logic xosc_d_r; // Previous oscillator level
    logic ext_d_r; // Previous external input level
    logic pre_wrap;
    logic xosc_edge;

    // Wrap point chosen by source; /48 and all other codes wrap at 47
    always_comb begin
        unique case (src_sel)
            asp_pkg::ASP_SRC_DIV4: pre_wrap = (pre_r == asp_pkg::ASP_DIV4_LAST);
            asp_pkg::ASP_SRC_DIV12: pre_wrap = (pre_r == asp_pkg::ASP_DIV12_LAST);
            default: pre_wrap = (pre_r == asp_pkg::ASP_DIV48_LAST);
        endcase
    end

    // Prescaler counter
    always_ff @(posedge ref_clk) begin
        if (rst || pre_wrap) begin
            pre_r <= 6'h00;
        end else begin
            pre_r <= pre_r + 6'h01;
        end
    end

    // Edge history of slow inputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            xosc_d_r <= 1'b0;
            ext_d_r <= 1'b0;
            xcnt_r <= 4'h0;
        end else begin
            xosc_d_r <= xosc_sync;
            ext_d_r <= ext_sync;
            if (xosc_edge) begin
                xcnt_r <= xcnt_r + 4'h1;
            end
        end
    end
    assign xosc_edge = xosc_sync ^ xosc_d_r;

    // Tick selection [RULE6]
    always_comb begin
        unique case (src_sel)
            asp_pkg::ASP_SRC_SYS: tick = 1'b1;
            asp_pkg::ASP_SRC_DIV4, asp_pkg::ASP_SRC_DIV12,
            asp_pkg::ASP_SRC_DIV48: tick = pre_wrap;
            asp_pkg::ASP_SRC_XOSC8: tick = xosc_edge && (xcnt_r == asp_pkg::ASP_XOSC_LAST);
            asp_pkg::ASP_SRC_EXT: tick = ext_sync && !ext_d_r;
            default: tick = 1'b0; // Unused codes stop the timer
        endcase
    end
endmodule // asp_tick_gen
`default_nettype wire

/* File: asp_skid_buf.sv */
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes both sides run on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module asp_skid_buf #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] mem_r [2]; // Two entries
    logic rd_r; // Read pointer
    logic wr_r; // Write pointer
    logic [1:0] cnt_r; // Fill count
    logic push;
    logic pop;

    assign in_ready = (cnt_r != 2'h2); // Full stalls the writer
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = mem_r[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and count update
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) begin
                wr_r <= !wr_r;
            end
            if (pop) begin
                rd_r <= !rd_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    // Entry write, no reset needed on data
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end
endmodule // asp_skid_buf
`default_nettype wire

/* File: asp_top_assertions.sv */
/*
 * Port checker for the asynchronous serial port.
 * Assumes it is bound to asp_top and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module asp_top_assertions (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic irq_enable,
    input wire logic serial_in_pin,
    input wire logic baud_timer_ext_input,
    input wire logic xosc_in,
    input wire logic serial_out_pin,
    input wire logic irq_req
);
    // ------------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------------
    logic [7:0] reload_r; // Shadow of the reload byte
    logic wrote_r; // A buffer write was seen since reset

    // Track reload writes so read-back can be judged
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reload_r <= asp_pkg::ASP_RST_BYTE;
        end else if (reg_wr && reg_addr == asp_pkg::ASP_ADDR_RELOAD) begin
            reload_r <= reg_wdata;
        end
    end

    // No buffer write yet means the line has no reason to move
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wrote_r <= 1'b0;
        end else if (reg_wr && reg_addr == asp_pkg::ASP_ADDR_BUF) begin
            wrote_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_idle_after_rst: assert property ($fell(rst) |-> serial_out_pin)
        else $error("transmit line not idle after reset");
    a_irq_after_rst: assert property ($fell(rst) |-> !irq_req)
        else $error("interrupt request high after reset");
    a_irq_gate_off: assert property (!irq_enable |=> !irq_req)
        else $error("interrupt request while disabled");
    a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_unmapped_rd: assert property (reg_rd && reg_addr > 3'h4 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_reload_rdback: assert property (reg_rd && reg_addr == asp_pkg::ASP_ADDR_RELOAD
        |=> reg_rdata == reload_r)
        else $error("reload byte read back wrong");
    a_tx_needs_wr: assert property (!wrote_r |-> serial_out_pin)
        else $error("line moved without a buffer write");
    a_start_min_width: assert property ($fell(serial_out_pin) |=> !serial_out_pin)
        else $error("start bit shorter than two cycles");
endmodule // asp_top_assertions

bind asp_top asp_top_assertions i_chk (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq_enable, .serial_in_pin, .baud_timer_ext_input, .xosc_in,
    .serial_out_pin, .irq_req);
`default_nettype wire

/* File: asp_peer_model.sv */
/*
 * Remote transceiver model: sends frames to the port, decodes its frames.
 * Assumes the bench sets the expected transmit bit length in cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module asp_peer_model (
    input wire logic ref_clk,
    input wire logic line_in,
    output logic line_out,
    input wire logic [7:0] bit_cyc,
    output logic [7:0] got_byte,
    output logic got_stop,
    output logic got_stb
);
    // Idle line high until a frame is sent
    initial begin
        line_out = 1'b1;
        got_stb = 1'b0;
    end

    // Start, eight bits LSB first, stop
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out <= f[i];
            repeat (bit_cyc) @(posedge ref_clk);
        end
        line_out <= 1'b1;
    endtask

    // Falling edge opens a frame; sample mid-bit
    initial forever begin
        @(negedge line_in);
        repeat (bit_cyc / 2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge ref_clk);
            got_byte[i] = line_in;
        end
        repeat (bit_cyc) @(posedge ref_clk);
        got_stop = line_in;
        got_stb = 1'b1;
        @(posedge ref_clk);
        got_stb = 1'b0;
    end
endmodule // asp_peer_model
`default_nettype wire

/* File: test_async_serial_port.sv */
/*
 * Self-checking bench for asp_top with a remote transceiver model.
 * Assumes the checker is bound and system clock is used as reference.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module test_async_serial_port;
    logic ref_clk, rst, reg_wr, reg_rd, irq_enable, serial_in_pin, serial_out_pin;
    logic ext_clk, xosc_clk, irq_req, got_stop, got_stb, rd_seen;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, bit_cyc, got_byte, rx_a;
    logic [7:0] exp_rd[$]; // Expected read data
    logic [7:0] exp_tx[$]; // Expected transmitted bytes
    logic [2:0] srcs[5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h4};
    logic [7:0] cycs[5] = '{8'd16, 8'd48, 8'd192, 8'd24, 8'd128}; // 4 ticks a bit
    int errors = 0;
    int total_checks = 0;
    int seed = 32'h1afa47ae;

    asp_top i_dut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .irq_enable, .serial_in_pin, .baud_timer_ext_input(ext_clk), .xosc_in(xosc_clk),
        .serial_out_pin, .irq_req);
    asp_peer_model i_peer (.ref_clk, .line_in(serial_out_pin), .line_out(serial_in_pin),
        .bit_cyc, .got_byte, .got_stop, .got_stb);

    // Clocks: system, and free-running external sources
    initial begin ref_clk = 0; forever #5 ref_clk = ~ref_clk; end
    initial begin ext_clk = 0; forever #30 ext_clk = ~ext_clk; end
    initial begin xosc_clk = 0; forever #20 xosc_clk = ~xosc_clk; end

    // ------------------------------------------------------------------
    // Bus and bookkeeping tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk); reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        exp_rd.push_back(e);
        @(posedge ref_clk); reg_rd <= 1'b1; reg_addr <= a;
        @(posedge ref_clk); reg_rd <= 1'b0;
    endtask
    task automatic send_tx(input logic [7:0] d);
        exp_tx.push_back(d);
        wr(asp_pkg::ASP_ADDR_BUF, d);
    endtask
    task automatic give_verdict;
        if (errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Bounded wait for the far side to take every byte
    task automatic drain;
        for (int n = 0; n < 4000 && exp_tx.size() != 0; n++) @(posedge ref_clk);
        if (exp_tx.size() != 0) begin errors++; give_verdict; end
    endtask

    // Watcher: read data in the cycle after the strobe, and received frames
    always @(posedge ref_clk) rd_seen <= reg_rd;
    always @(negedge ref_clk) begin
        if (rd_seen) `CHK(reg_rdata, exp_rd.pop_front())
        if (got_stb === 1'b1) `CHK({got_stop, got_byte}, {1'b1, exp_tx.pop_front()})
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
        irq_enable = 0; bit_cyc = 8'd4;
        repeat (5) @(posedge ref_clk);
        rst <= 0;
        rd(asp_pkg::ASP_ADDR_CTRL, 8'h00);
        rd(asp_pkg::ASP_ADDR_RELOAD, 8'h00);
        rd(3'h7, 8'h00);
        wr(asp_pkg::ASP_ADDR_RELOAD, 8'hfe);
        wr(asp_pkg::ASP_ADDR_TCFG, 8'h08);
        rd(asp_pkg::ASP_ADDR_RELOAD, 8'hfe);
        send_tx(8'($random(seed)));
        send_tx(8'($random(seed)));
        drain;
        rd(asp_pkg::ASP_ADDR_CTRL, 8'h02);
        @(posedge ref_clk); #1;
        `CHK(irq_req, 1'b0)
        irq_enable <= 1'b1;
        repeat (3) @(posedge ref_clk); #1;
        `CHK(irq_req, 1'b1)
        wr(asp_pkg::ASP_ADDR_CTRL, 8'h00);
        repeat (3) @(posedge ref_clk); #1;
        `CHK(irq_req, 1'b0)
        i_peer.send(8'($random(seed)), 1'b1);
        repeat (20) @(posedge ref_clk);
        rd(asp_pkg::ASP_ADDR_CTRL, 8'h00);
        wr(asp_pkg::ASP_ADDR_CTRL, 8'h10);
        rx_a = 8'($random(seed));
        fork
            i_peer.send(rx_a, 1'b1);
            send_tx(8'($random(seed)));
        join
        drain;
        repeat (20) @(posedge ref_clk);
        rd(asp_pkg::ASP_ADDR_CTRL, 8'h17);
        rd(asp_pkg::ASP_ADDR_BUF, rx_a);
        i_peer.send(~rx_a, 1'b1);
        repeat (20) @(posedge ref_clk);
        rd(asp_pkg::ASP_ADDR_BUF, rx_a);
        wr(asp_pkg::ASP_ADDR_CTRL, 8'h30);
        i_peer.send(~rx_a, 1'b0);
        repeat (20) @(posedge ref_clk);
        rd(asp_pkg::ASP_ADDR_CTRL, 8'h30);
        rd(asp_pkg::ASP_ADDR_BUF, rx_a);
        i_peer.send(~rx_a, 1'b1);
        repeat (20) @(posedge ref_clk);
        rd(asp_pkg::ASP_ADDR_CTRL, 8'h35);
        rd(asp_pkg::ASP_ADDR_BUF, ~rx_a);
        // Each timer source other than the system clock stretches the bit to its own length
        for (int i = 0; i < 5; i++) begin
            wr(asp_pkg::ASP_ADDR_TCFG, {5'h01, srcs[i]});
            bit_cyc = cycs[i];
            send_tx(8'($random(seed)));
            drain;
        end
        give_verdict;
    end
endmodule // test_async_serial_port
`default_nettype wire
